/* File: verilog/touch_standby_pkg.sv */
// Purpose: shared constants and types for the standby touch sampler
// Assumes: 100 MHz system clock
// Notes: register offsets are byte addresses of the 8-bit register port
package touch_standby_pkg;
    // ****************************************
    // register offsets and reset values
    // ****************************************
    localparam logic [7:0] OFS_NOISE_LOW = 8'h38;
    localparam logic [7:0] OFS_NOISE_HIGH = 8'h39;
    localparam logic [7:0] OFS_CHAN_SELECT = 8'h40;
    localparam logic [7:0] OFS_SETUP = 8'h41;
    localparam logic [7:0] OFS_GAIN = 8'h42;
    localparam logic [7:0] OFS_LEVEL = 8'h43;
    localparam logic [7:0] RST_NOISE = 8'h55;
    localparam logic [7:0] RST_CHAN_SELECT = 8'h00;
    localparam logic [7:0] RST_SETUP = 8'h1d;
    localparam logic [7:0] RST_GAIN = 8'h02;
    localparam logic [7:0] RST_LEVEL = 8'h40;
    // writable bits; the rest read as zero
    localparam logic [7:0] MASK_SETUP = 8'hbf;
    localparam logic [7:0] MASK_GAIN = 8'h07;
    localparam logic [7:0] MASK_LEVEL = 8'h7f;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 100;
    localparam int SAMPLE_SHORT_US = 1280;
    localparam int SAMPLE_LONG_US = 2560;
    localparam int CYCLE_STEP_MS = 35;
    localparam int SAMPLE_SHORT_CYC = SAMPLE_SHORT_US * CLK_MHZ;
    localparam int SAMPLE_LONG_CYC = SAMPLE_LONG_US * CLK_MHZ;
    localparam int CYCLE_STEP_CYC = CYCLE_STEP_MS * 1000 * CLK_MHZ;
    // ****************************************
    // widths and types
    // ****************************************
    localparam int RAW_W = 16;
    localparam int ACC_W = 24;
    localparam int TMR_W = 24;
    localparam int CHANNELS = 8;

    typedef struct packed {
        logic accumulateSelect;
        logic spare;
        logic [2:0] standbySampleCount;
        logic standbySamplePeriod;
        logic [1:0] standbyCyclePeriod;
    } setup_t;

    typedef struct packed {
        logic [2:0] channel;
        logic [7:0] delta;
        logic touch;
        logic noise;
    } meas_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SEEK = 4'b0010,
        ST_SAMPLE = 4'b0100,
        ST_JUDGE = 4'b1000
    } state_t;
endpackage

/* File: verilog/standby_cycle_timer.sv */
// Purpose: standby cycle period timer with stretch while sampling
// Assumes: run is a same-clock level from power control
// Notes: a cycle start is issued at once when run rises
`timescale 1ns/1ps
module standby_cycle_timer
    import touch_standby_pkg::*;
#(
    parameter logic [TMR_W-1:0] STEP_CYC = TMR_W'(CYCLE_STEP_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic run,
    input wire logic busy,
    input wire logic [1:0] cyclePeriod,
    output logic cycleStart,
    output logic extended
);
    logic [TMR_W+1:0] count;
    logic first;
    // three bits so that code 3 gives four steps rather than wrapping to zero
    wire [2:0] periodSteps = {1'b0, cyclePeriod} + 3'd1;
    wire [TMR_W+1:0] limit = (TMR_W+2)'(STEP_CYC) * (TMR_W+2)'(periodSteps);
    wire due = first || (count >= limit - (TMR_W+2)'(1));
    wire fire = run && due && !busy;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            first <= 1'b1;
            cycleStart <= 1'b0;
            extended <= 1'b0;
        end else begin
            cycleStart <= fire;
            if (!run) begin
                count <= '0;
                first <= 1'b1;
                extended <= 1'b0;
            end else if (fire) begin
                count <= '0;
                first <= 1'b0;
                extended <= 1'b0;
            end else if (due) begin
                extended <= busy;
            end else begin
                count <= count + (TMR_W+2)'(1);
            end
        end
    end
endmodule

/* File: verilog/standby_delta_judge.sv */
// Purpose: forms scaled delta and compares it with touch and noise limits
// Assumes: accum holds the sum of all samples of one measurement
// Notes: result is registered, one cycle after valid
`timescale 1ns/1ps
module standby_delta_judge
    import touch_standby_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic valid,
    input wire logic [2:0] channel,
    input wire logic [ACC_W-1:0] accum,
    input wire logic accumulateSelect,
    input wire logic [2:0] countCode,
    input wire logic [2:0] gainCode,
    input wire logic [6:0] level,
    input wire logic [1:0] fracCode,
    output meas_t result,
    output logic resultValid
);
    function automatic logic [7:0] noise_limit(input logic [6:0] lv, input logic [1:0] code);
        logic [7:0] q;
        logic [7:0] e;
        q = {3'b000, lv[6:2]};
        e = {4'h0, lv[6:3]};
        case (code)
            2'b00: noise_limit = q;
            2'b01: noise_limit = q + e;
            2'b10: noise_limit = {2'b00, lv[6:1]};
            default: noise_limit = {2'b00, lv[6:1]} + e;
        endcase
    endfunction

    wire [ACC_W-1:0] delta = accumulateSelect ? accum : (accum >> countCode);
    wire [ACC_W:0] scaledWide = {delta, 1'b0} >> gainCode;
    wire [7:0] scaled = (|scaledWide[ACC_W:8]) ? 8'hff : scaledWide[7:0];
    wire [7:0] noiseLim = noise_limit(level, fracCode);
    wire isTouch = scaled > {1'b0, level};
    wire isNoise = (scaled > noiseLim) && !isTouch;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result <= '0;
            resultValid <= 1'b0;
        end else begin
            resultValid <= valid;
            if (valid) begin
                result <= '{channel: channel, delta: scaled, touch: isTouch, noise: isNoise};
            end
        end
    end
endmodule

/* File: verilog/touch_standby_noise_config.sv */
// Purpose: standby sampling sequencer, its registers and noise-spike filter
// Assumes: front end and register port run on clk_sys, no synchronisers
// Notes: front end count is taken at the end of each sample period
//
// Behaviour
// - spike between noise and touch skips recalibration
// - noise fraction code 25/37.5/50/62.5 percent
// - two noise registers, channel pairs low to high from bit 0
// - per-channel standby sampling enable bit
// - standby channels use standby settings
// - bit7 selects average or sum
// - bits5-3 sample count, samples back to back
// - bit2 sample period 2.56 or 1.28 ms
// - bits1-0 cycle 35/70/105/140 ms
// - sample at cycle start, then idle
// - cycle stretches until sampling completes
// - gain code 128x halving to 1x
// - delta msb 64 raw at 128x
// - touch when delta exceeds standby level
`timescale 1ns/1ps
module touch_standby_noise_config
    import touch_standby_pkg::*;
#(
    parameter logic [TMR_W-1:0] SAMPLE_SHORT = TMR_W'(SAMPLE_SHORT_CYC),
    parameter logic [TMR_W-1:0] SAMPLE_LONG = TMR_W'(SAMPLE_LONG_CYC),
    parameter logic [TMR_W-1:0] CYCLE_STEP = TMR_W'(CYCLE_STEP_CYC)
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    output logic [7:0] regRdData,
    input wire logic standbyMode,
    input wire logic [RAW_W-1:0] afeCount,
    output logic sampleStart,
    output logic [2:0] sampleChannel,
    output logic lowPowerIdle,
    output logic cycleExtended,
    output logic measValid,
    output meas_t meas,
    output logic recalSample,
    output logic [CHANNELS-1:0] touchStatus
);
    // ****************************************
    // register bank
    // ****************************************
    logic [7:0] noiseLow;
    logic [7:0] noiseHigh;
    logic [7:0] standbyChannelEnable;
    setup_t setup;
    logic [2:0] standbyGainCode;
    logic [6:0] standbyLevel;

    wire wrNoiseLow = regWrite && (regAddr == OFS_NOISE_LOW);
    wire wrNoiseHigh = regWrite && (regAddr == OFS_NOISE_HIGH);
    wire wrChan = regWrite && (regAddr == OFS_CHAN_SELECT);
    wire wrSetup = regWrite && (regAddr == OFS_SETUP);
    wire wrGain = regWrite && (regAddr == OFS_GAIN);
    wire wrLevel = regWrite && (regAddr == OFS_LEVEL);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            noiseLow <= RST_NOISE;
            noiseHigh <= RST_NOISE;
            standbyChannelEnable <= RST_CHAN_SELECT;
            setup <= setup_t'(RST_SETUP);
            standbyGainCode <= RST_GAIN[2:0];
            standbyLevel <= RST_LEVEL[6:0];
        end else begin
            if (wrNoiseLow) noiseLow <= regWrData;
            if (wrNoiseHigh) noiseHigh <= regWrData;
            if (wrChan) standbyChannelEnable <= regWrData;
            if (wrSetup) setup <= setup_t'(regWrData & MASK_SETUP);
            if (wrGain) standbyGainCode <= regWrData[2:0];
            if (wrLevel) standbyLevel <= regWrData[6:0];
        end
    end

    // unmapped offsets read as zero
    logic [7:0] readMux;
    always_comb begin
        case (regAddr)
            OFS_NOISE_LOW: readMux = noiseLow;
            OFS_NOISE_HIGH: readMux = noiseHigh;
            OFS_CHAN_SELECT: readMux = standbyChannelEnable;
            OFS_SETUP: readMux = 8'(setup) & MASK_SETUP;
            OFS_GAIN: readMux = {5'h00, standbyGainCode} & MASK_GAIN;
            OFS_LEVEL: readMux = {1'b0, standbyLevel} & MASK_LEVEL;
            default: readMux = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            regRdData <= 8'h00;
        end else begin
            regRdData <= readMux;
        end
    end

    // ****************************************
    // decoding helpers
    // ****************************************
    // code n gives 2^n samples
    function automatic logic [7:0] sample_last(input logic [2:0] code);
        sample_last = (8'h01 << code) - 8'h01;
    endfunction

    // pair ch of the sixteen code bits
    function automatic logic [1:0] frac_of(input logic [15:0] codes, input logic [2:0] ch);
        frac_of = codes[{ch, 1'b0} +: 2];
    endfunction

    // ****************************************
    // sequencer
    // ****************************************
    state_t state;
    state_t next_state;
    logic [2:0] chIdx;
    logic [7:0] sampleNum;
    logic [TMR_W-1:0] sampleTimer;
    logic [ACC_W-1:0] accum;
    logic judgeValid;
    logic cycleStart;
    logic timerExtended;
    meas_t judgeResult;
    logic judgeDone;

    wire busy = (state != ST_IDLE);
    wire chEnabled = standbyChannelEnable[chIdx];
    wire lastChannel = (chIdx == 3'd7);
    // bit2 high gives the shorter sample
    wire [TMR_W-1:0] samplePeriodCyc = setup.standbySamplePeriod ? SAMPLE_SHORT : SAMPLE_LONG;
    wire sampleEnd = (state == ST_SAMPLE) && (sampleTimer == '0);
    // samples of one channel back to back
    wire lastSample = (sampleNum == sample_last(setup.standbySampleCount));
    // no new sample once standby is left, the sequencer is aborting
    wire startNow = standbyMode && ((state == ST_SEEK && chEnabled) || (sampleEnd && !lastSample));
    wire [1:0] fracCode = frac_of({noiseHigh, noiseLow}, chIdx);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (cycleStart && standbyMode) next_state = ST_SEEK;
            end
            ST_SEEK: begin
                if (!standbyMode) next_state = ST_IDLE;
                else if (chEnabled) next_state = ST_SAMPLE;
                else if (lastChannel) next_state = ST_IDLE;
            end
            ST_SAMPLE: begin
                if (!standbyMode) next_state = ST_IDLE;
                else if (sampleEnd && lastSample) next_state = ST_JUDGE;
            end
            ST_JUDGE: begin
                next_state = lastChannel ? ST_IDLE : ST_SEEK;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            chIdx <= 3'd0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE) chIdx <= 3'd0;
            else if ((state == ST_SEEK && !chEnabled) || state == ST_JUDGE) chIdx <= chIdx + 3'd1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sampleTimer <= '0;
            sampleNum <= 8'h00;
            accum <= '0;
        end else begin
            if (startNow) sampleTimer <= samplePeriodCyc - TMR_W'(1);
            else if (state == ST_SAMPLE && sampleTimer != '0) sampleTimer <= sampleTimer - TMR_W'(1);
            if (state == ST_SEEK) begin
                sampleNum <= 8'h00;
                accum <= '0;
            end else if (sampleEnd) begin
                sampleNum <= sampleNum + 8'h01;
                accum <= accum + {{(ACC_W-RAW_W){1'b0}}, afeCount};
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sampleStart <= 1'b0;
            sampleChannel <= 3'd0;
            lowPowerIdle <= 1'b1;
            judgeValid <= 1'b0;
        end else begin
            sampleStart <= startNow;
            if (startNow) sampleChannel <= chIdx;
            // idle for the rest of the cycle
            lowPowerIdle <= (next_state == ST_IDLE);
            judgeValid <= (next_state == ST_JUDGE);
        end
    end

    standby_cycle_timer #(
        .STEP_CYC(CYCLE_STEP)
    ) u_cycle (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(standbyMode),
        .busy(busy),
        .cyclePeriod(setup.standbyCyclePeriod),
        .cycleStart(cycleStart),
        .extended(timerExtended)
    );

    // standby level, count, mode and gain
    standby_delta_judge u_judge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .valid(judgeValid),
        .channel(chIdx),
        .accum(accum),
        .accumulateSelect(setup.accumulateSelect),
        .countCode(setup.standbySampleCount),
        .gainCode(standbyGainCode),
        .level(standbyLevel),
        .fracCode(fracCode),
        .result(judgeResult),
        .resultValid(judgeDone)
    );

    // ****************************************
    // results
    // ****************************************
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            measValid <= 1'b0;
            meas <= '0;
            recalSample <= 1'b0;
            cycleExtended <= 1'b0;
        end else begin
            measValid <= judgeDone;
            if (judgeDone) meas <= judgeResult;
            recalSample <= judgeDone && !judgeResult.noise && !judgeResult.touch;
            // never flagged while the sequencer is already idle
            cycleExtended <= timerExtended && (next_state != ST_IDLE);
        end
    end

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_touch
            wire hit = judgeDone && (judgeResult.channel == 3'(g));
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    touchStatus[g] <= 1'b0;
                end else if (!standbyMode) begin
                    touchStatus[g] <= 1'b0;
                end else if (hit) begin
                    touchStatus[g] <= judgeResult.touch;
                end
            end
        end
    endgenerate
endmodule

/* File: verif/touch_standby_properties.sv */
// Purpose: port-level checks of the standby sampler
// Assumes: sample period of at least four clocks
// Notes: bound to every instance of the top module
`timescale 1ns/1ps
module touch_standby_properties
    import touch_standby_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic [7:0] regRdData,
    input wire logic standbyMode,
    input wire logic [RAW_W-1:0] afeCount,
    input wire logic sampleStart,
    input wire logic [2:0] sampleChannel,
    input wire logic lowPowerIdle,
    input wire logic cycleExtended,
    input wire logic measValid,
    input wire meas_t meas,
    input wire logic recalSample,
    input wire logic [CHANNELS-1:0] touchStatus
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    recal_when_clean_a: assert property (
        measValid |-> recalSample == (!meas.touch && !meas.noise))
        else $error("recal pulse disagrees with judged sample");
    recal_needs_valid_a: assert property (recalSample |-> measValid)
        else $error("recal pulse without a result");
    spike_not_touch_a: assert property (measValid |-> !(meas.touch && meas.noise))
        else $error("sample flagged both touch and noise");
    status_tracks_a: assert property (
        measValid |-> touchStatus[meas.channel] == meas.touch)
        else $error("touch status differs from result");
    // shortest legal period is four clocks
    sample_spacing_a: assert property (sampleStart |=> !sampleStart [*3])
        else $error("samples closer than one period");
    busy_not_idle_a: assert property ((sampleStart || cycleExtended) |-> !lowPowerIdle)
        else $error("idle while sampling");
    off_goes_idle_a: assert property (
        !standbyMode [*3] |-> lowPowerIdle && touchStatus == 8'h00)
        else $error("not idle after standby left");
    select_readback_a: assert property (
        regWrite && regAddr == 8'h40 ##1 !regWrite && regAddr == 8'h40
        |=> regRdData == $past(regWrData, 2))
        else $error("channel select did not take written value");
    gain_spare_zero_a: assert property (regAddr == 8'h42 |=> regRdData[7:3] == 5'h00)
        else $error("gain register spare bits not zero");

    cover property (measValid && meas.touch);
    cover property (measValid && meas.noise);
    cover property (cycleExtended);
    cover property (recalSample);
endmodule

bind touch_standby_noise_config touch_standby_properties chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
    .regRdData(regRdData), .standbyMode(standbyMode), .afeCount(afeCount),
    .sampleStart(sampleStart), .sampleChannel(sampleChannel), .lowPowerIdle(lowPowerIdle),
    .cycleExtended(cycleExtended), .measValid(measValid), .meas(meas),
    .recalSample(recalSample), .touchStatus(touchStatus));

/* File: verif/touch_front_end_model.sv */
// Purpose: front end stand-in returning a set count per channel
// Assumes: period input equals the sample period in clocks
// Notes: outside a sample the count toggles so stale data never matches
`timescale 1ns/1ps
module touch_front_end_model
    import touch_standby_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sampleStart,
    input wire logic [2:0] sampleChannel,
    input wire logic [7:0][RAW_W-1:0] chanVal,
    input wire logic [3:0] period,
    output logic [RAW_W-1:0] afeCount
);
    logic [3:0] left = 4'h0;

    initial afeCount = 16'h0;

    // hold through the last cycle of the sample, then let go
    always @(posedge clk_sys) begin
        if (sampleStart) begin
            afeCount <= chanVal[sampleChannel];
            left <= period - 4'h1;
        end else begin
            if (left != 4'h0) left <= left - 4'h1;
            if (left <= 4'h1) afeCount <= ~afeCount;
        end
    end
endmodule

/* File: verif/touch_standby_noise_config_tb.sv */
// Purpose: self-checking bench for the standby sampler
// Assumes: shortened sample and cycle timing
// Notes: expected results come from an integer model of the rules
`timescale 1ns/1ps
module touch_standby_noise_config_tb
    import touch_standby_pkg::*;
;
    localparam int PS = 4;
    localparam int PL = 8;
    localparam int STEP = 200;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic standbyMode = 1'b0;
    logic [7:0][RAW_W-1:0] chanVal = '0;
    logic [RAW_W-1:0] afeCount;
    logic [7:0] regRdData;
    logic sampleStart, lowPowerIdle, cycleExtended, measValid, recalSample;
    logic [2:0] sampleChannel;
    meas_t meas;
    logic [7:0] touchStatus;
    logic prevIdle = 1'b1;
    int bad_count = 0;
    int n_checks = 0;
    int live = 0, ext, cyc = 0, lastFall, nMeas, nSamp, nextCh;
    int mask, acc, cnt, per, cc, gain, level, v, n, d, s, f, lim, tch, nz;
    int frac [8];
    logic [7:0] ra [8] = '{8'h38, 8'h39, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h00};
    logic [7:0] rv [8] = '{8'h55, 8'h55, 8'h00, 8'h1d, 8'h02, 8'h40, 8'h00, 8'h00};

    always #5 clk_sys = ~clk_sys;

    touch_standby_noise_config #(.SAMPLE_SHORT(24'd4), .SAMPLE_LONG(24'd8),
        .CYCLE_STEP(24'd200)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRdData(regRdData),
        .standbyMode(standbyMode), .afeCount(afeCount), .sampleStart(sampleStart),
        .sampleChannel(sampleChannel), .lowPowerIdle(lowPowerIdle),
        .cycleExtended(cycleExtended), .measValid(measValid), .meas(meas),
        .recalSample(recalSample), .touchStatus(touchStatus));

    touch_front_end_model fe (.clk_sys(clk_sys), .sampleStart(sampleStart),
        .sampleChannel(sampleChannel), .chanVal(chanVal),
        .period(per != 0 ? 4'(PS) : 4'(PL)), .afeCount(afeCount));

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] o);
        n_checks++;
        if (o !== e) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", nm, e, o);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dt);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= dt;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        regAddr <= a;
        @(posedge clk_sys);
        #1;
        chk("register", e, regRdData);
    endtask

    function automatic int nxt(input int c);
        for (int k = 1; k <= 8; k++) begin
            if (mask[(c + k) % 8]) return (c + k) % 8;
        end
        return c;
    endfunction

    // ****************************************
    // result monitor
    // ****************************************
    always @(posedge clk_sys) begin
        #1;
        cyc++;
        if (live != 0 && cycleExtended) ext = 1;
        if (live != 0 && prevIdle && !lowPowerIdle) begin
            if (lastFall >= 0 && ext == 0) chk("cycle", (cc + 1) * STEP, cyc - lastFall);
            lastFall = cyc;
        end
        prevIdle = lowPowerIdle;
        if (live != 0 && measValid) begin
            v = int'(chanVal[nextCh]);
            n = 1 << cnt;
            d = acc != 0 ? n * v : v;
            s = (d * 2) >> gain;
            if (s > 255) s = 255;
            f = frac[nextCh];
            lim = f == 0 ? level >> 2 : f == 1 ? (level >> 2) + (level >> 3)
                : f == 2 ? level >> 1 : (level >> 1) + (level >> 3);
            tch = s > level;
            nz = (s > lim && tch == 0);
            chk("samples", n, nSamp);
            chk("channel", nextCh, meas.channel);
            chk("delta", s, meas.delta);
            chk("touch", tch, meas.touch);
            chk("noise", nz, meas.noise);
            chk("recal", (tch == 0 && nz == 0), recalSample);
            chk("status", tch, touchStatus[nextCh]);
            nSamp = 0;
            nMeas++;
            nextCh = nxt(nextCh);
        end
        // after the result: the next channel may start in the same cycle
        if (live != 0 && sampleStart) begin
            nSamp++;
            chk("sample channel", nextCh, sampleChannel);
        end
    end

    initial begin
        repeat (90000) @(posedge clk_sys);
        bad_count++;
        results();
    end

    initial begin
        int nl, nh, k;
        void'($urandom(29));
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (k = 0; k < 8; k++) rd(ra[k], rv[k]);
        wr(8'h41, 8'hff);
        rd(8'h41, 8'hbf);
        wr(8'h42, 8'hff);
        rd(8'h42, 8'h07);
        $display("register test done");
        // eight plain runs cover every cycle and gain code and sample count codes 0-3; the ninth overruns its cycle
        for (int t = 0; t < 9; t++) begin
            mask = t < 8 ? $urandom_range(1, 255) : 255;
            cnt = t < 8 ? t % 4 : 7;
            cc = t < 8 ? t % 4 : 0;
            acc = t % 2;
            per = (t >> 2) & 1;
            gain = t % 8;
            level = $urandom_range(8, 127);
            nl = $urandom_range(0, 255);
            nh = $urandom_range(0, 255);
            for (k = 0; k < 8; k++) begin
                frac[k] = k < 4 ? (nl >> (2 * k)) & 3 : (nh >> (2 * k - 8)) & 3;
                chanVal[k] <= RAW_W'($urandom_range(0, acc != 0 ? 40 : 255));
            end
            wr(8'h38, 8'(nl));
            wr(8'h39, 8'(nh));
            wr(8'h40, 8'(mask));
            wr(8'h41, {acc[0], 1'b0, cnt[2:0], per[0], cc[1:0]});
            wr(8'h42, 8'(gain));
            wr(8'h43, 8'(level));
            ext = 0;
            lastFall = -1;
            nSamp = 0;
            nMeas = 0;
            nextCh = nxt(7);
            live = 1;
            @(posedge clk_sys);
            standbyMode <= 1'b1;
            for (k = 0; k < 40000 && nMeas < 2 * $countones(mask); k++) @(posedge clk_sys);
            chk("results", 2 * $countones(mask), nMeas);
            chk("extended", t == 8, ext);
            live = 0;
            standbyMode <= 1'b0;
            repeat (4) @(posedge clk_sys);
            #1;
            chk("status off", 0, touchStatus);
            chk("idle", 1, lowPowerIdle);
            $display("standby test %0d done", t);
        end
        results();
    end
endmodule
